// >>> logic/lep_pkg.sv
package lep_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] LEP_ADDR_CTRL = 5'h1d;
    localparam logic [4:0] LEP_ADDR_IRQ_STAT = 5'h1e;
    localparam logic [4:0] LEP_ADDR_IRQ_MASK = 5'h1f;
    localparam int LEP_BIT_EN = 15;
    localparam int LEP_BIT_WAKE = 14;
    localparam int LEP_BIT_SLEEP = 13;
    localparam int LEP_BIT_MAN = 12;
    localparam int LEP_BIT_BDIS = 11;
    localparam int LEP_BIT_PWR = 10;
    localparam int LEP_BIT_ERRMET = 9;
    localparam int LEP_BIT_DATAMET = 8;
    localparam logic [3:0] LEP_THR_RST = 4'h1;
    localparam logic [15:0] LEP_CTRL_RST = 16'h6011;
    // Interrupt status bits
    localparam int LEP_IRQ_UP = 0;
    localparam int LEP_IRQ_DOWN = 1;
    localparam int LEP_IRQ_DATA = 2;
    localparam int LEP_IRQ_ERR = 3;
    localparam int LEP_IRQ_W = 4;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint LEP_CLK_HZ = 250000000;
    localparam longint LEP_IDLE_MS = 2000;
    localparam longint LEP_IDLE_CYC = (LEP_IDLE_MS * LEP_CLK_HZ) / 1000;
    localparam int LEP_BURST_LEN = 4;
    localparam int LEP_PULSE_CYC = 8;

    typedef enum logic [1:0] {LEP_DOWN, LEP_UP} lep_pwr_t;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } lep_bus_t;
endpackage

// >>> logic/lep_power_ctrl.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Energy sensing only while enable bit set
// - Auto-wake when data count reaches threshold
// - Auto-sleep when no line energy
// - Manual toggle flips power state immediately
// - Four pulses per power-up by default
// - One pulse when train disabled
// - Power-state bit reflects powered-up state
// - Power-state bit meaningless when disabled
// - Counters clear after two idle seconds
// - Data-threshold flag sets, clears on read
// - Both thresholds reset to one
module lep_power_ctrl
    import lep_pkg::*;
#(
    parameter longint IDLE_CYC = LEP_IDLE_CYC
)(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Line sense inputs (asynchronous)
    input wire logic energy_in,
    input wire logic data_event_in,
    input wire logic error_event_in,
    // Line section control and interrupt
    output logic line_power_out,
    output logic sense_pulse_out,
    output logic irq_out
);
    typedef struct packed {
        logic [2:0] energy_sync;
        logic [2:0] data_sync;
        logic [2:0] err_sync;
        logic en;
        logic wake;
        logic sleep;
        logic man;
        logic bdis;
        logic [3:0] err_thr;
        logic [3:0] data_thr;
        logic data_met;
        logic err_met;
        lep_pwr_t pwr;
        logic [3:0] data_cnt;
        logic [3:0] err_cnt;
        logic [39:0] idle;
        logic [LEP_IRQ_W-1:0] stat;
        logic [LEP_IRQ_W-1:0] mask;
        logic [15:0] rdata;
        logic irq;
        logic start;
        logic line_pwr;
    } lep_st_t;
    lep_st_t s_r, s_nxt;
    lep_bus_t bus;
    logic pulse_w;
    logic busy_w;

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic data_ev;
        logic err_ev;
        logic energy;
        logic go_up;
        logic go_down;
        logic [LEP_IRQ_W-1:0] ev;
        logic [15:0] ctrl_rd;
        data_ev = 1'b0;
        err_ev = 1'b0;
        energy = 1'b0;
        go_up = 1'b0;
        go_down = 1'b0;
        ev = '0;
        ctrl_rd = '0;
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        // Third stage only for edge detection; first stage feeds second only
        s_nxt.energy_sync = {s_r.energy_sync[1:0], energy_in};
        s_nxt.data_sync = {s_r.data_sync[1:0], data_event_in};
        s_nxt.err_sync = {s_r.err_sync[1:0], error_event_in};
        energy = s_r.energy_sync[1];
        data_ev = s_r.data_sync[1] && !s_r.data_sync[2];
        err_ev = s_r.err_sync[1] && !s_r.err_sync[2];

        // Event counters saturate; cleared after a long quiet spell
        if (data_ev)
        begin
            s_nxt.idle = '0;
            if (s_r.data_cnt != 4'hf)
                s_nxt.data_cnt = s_r.data_cnt + 4'h1;
        end
        else if (s_r.idle >= 40'(IDLE_CYC - 1))
        begin
            s_nxt.idle = '0;
            s_nxt.data_cnt = '0;
            s_nxt.err_cnt = '0;
        end
        else
            s_nxt.idle = s_r.idle + 40'h1;
        // Counts on from the cleared value when an error lands on the expiry
        if (err_ev && s_nxt.err_cnt != 4'hf)
            s_nxt.err_cnt = s_nxt.err_cnt + 4'h1;

        ev[LEP_IRQ_DATA] = (s_nxt.data_cnt >= s_r.data_thr) && data_ev;
        ev[LEP_IRQ_ERR] = (s_nxt.err_cnt >= s_r.err_thr) && err_ev;

        // Power state machine
        if (s_r.en)
        begin
            case (s_r.pwr)
                LEP_DOWN:
                    go_up = s_r.man || (s_r.wake && s_r.data_cnt >= s_r.data_thr);
                LEP_UP:
                    go_down = s_r.man || (s_r.sleep && !energy);
                default:
                    go_down = 1'b1;
            endcase
        end
        if (go_up)
        begin
            s_nxt.pwr = LEP_UP;
            s_nxt.start = 1'b1;
            s_nxt.data_cnt = '0;
            s_nxt.err_cnt = '0;
        end
        else if (go_down)
            s_nxt.pwr = LEP_DOWN;
        ev[LEP_IRQ_UP] = go_up;
        ev[LEP_IRQ_DOWN] = go_down;
        s_nxt.man = 1'b0;

        ctrl_rd = {s_r.en, s_r.wake, s_r.sleep, 1'b0, s_r.bdis, (s_r.pwr == LEP_UP),
                   s_r.err_met, s_r.data_met, s_r.err_thr, s_r.data_thr};

        // Register reads; flags clear on read, a same-cycle set still wins
        s_nxt.rdata = '0;
        if (bus.rd)
        begin
            case (bus.addr)
                LEP_ADDR_CTRL:
                begin
                    s_nxt.rdata = ctrl_rd;
                    s_nxt.data_met = 1'b0;
                    s_nxt.err_met = 1'b0;
                end
                LEP_ADDR_IRQ_STAT: s_nxt.rdata = 16'(s_r.stat);
                LEP_ADDR_IRQ_MASK: s_nxt.rdata = 16'(s_r.mask);
                default: s_nxt.rdata = '0;
            endcase
        end
        if (bus.wr)
        begin
            case (bus.addr)
                LEP_ADDR_CTRL:
                begin
                    s_nxt.en = bus.wdata[LEP_BIT_EN];
                    s_nxt.wake = bus.wdata[LEP_BIT_WAKE];
                    s_nxt.sleep = bus.wdata[LEP_BIT_SLEEP];
                    s_nxt.man = bus.wdata[LEP_BIT_MAN];
                    s_nxt.bdis = bus.wdata[LEP_BIT_BDIS];
                    s_nxt.err_thr = bus.wdata[7:4];
                    s_nxt.data_thr = bus.wdata[3:0];
                end
                LEP_ADDR_IRQ_STAT: s_nxt.stat = s_r.stat & ~bus.wdata[LEP_IRQ_W-1:0];
                LEP_ADDR_IRQ_MASK: s_nxt.mask = bus.wdata[LEP_IRQ_W-1:0];
                default: ;
            endcase
        end
        if (ev[LEP_IRQ_DATA])
            s_nxt.data_met = 1'b1;
        if (ev[LEP_IRQ_ERR])
            s_nxt.err_met = 1'b1;
        s_nxt.stat = s_nxt.stat | ev;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
        // Registered so the pin cannot glitch when enable and state change together
        s_nxt.line_pwr = !s_nxt.en || (s_nxt.pwr == LEP_UP);
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            s_r <= '0;
            s_r.wake <= LEP_CTRL_RST[LEP_BIT_WAKE];
            s_r.sleep <= LEP_CTRL_RST[LEP_BIT_SLEEP];
            s_r.err_thr <= LEP_THR_RST;
            s_r.data_thr <= LEP_THR_RST;
            s_r.pwr <= LEP_DOWN;
            s_r.line_pwr <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------------
    // Power-up pulse train
    // ------------------------------------------------------------------
    lep_pulse_gen u_pulse (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .start_in(s_r.start),
        .single_in(s_r.bdis),
        .pulse_out(pulse_w),
        .busy_out(busy_w)
    );

    assign reg_rdata_out = s_r.rdata;
    // Line kept powered whenever sensing is off; state bit ignored then
    assign line_power_out = s_r.line_pwr;
    assign sense_pulse_out = pulse_w;
    assign irq_out = s_r.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_disabled_hold;
        @(posedge mclk_in) disable iff (reset_in)
        !s_r.en |=> $stable(s_r.pwr);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("power moved while disabled");

    property p_wake;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.en && s_r.wake && s_r.pwr == LEP_DOWN && s_r.data_cnt >= s_r.data_thr
        |=> s_r.pwr == LEP_UP;
    endproperty
    a_wake: assert property (p_wake) else $error("auto wake missed");

    property p_sleep;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.en && s_r.sleep && s_r.pwr == LEP_UP && !s_r.energy_sync[1] |=> s_r.pwr == LEP_DOWN;
    endproperty
    a_sleep: assert property (p_sleep) else $error("auto sleep missed");

    property p_man;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.en && s_r.man |=> s_r.pwr != $past(s_r.pwr);
    endproperty
    a_man: assert property (p_man) else $error("manual toggle ignored");

    property p_burst;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.start && !busy_w && !s_r.bdis |=> pulse_w [*8] ##1 !pulse_w [*8] ##1 pulse_w;
    endproperty
    a_burst: assert property (p_burst) else $error("burst shape wrong");

    property p_single;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.start && !busy_w && s_r.bdis |=> pulse_w [*8] ##1 !pulse_w [*8] ##1 !busy_w;
    endproperty
    a_single: assert property (p_single) else $error("single pulse wrong");

    property p_state_read;
        @(posedge mclk_in) disable iff (reset_in)
        bus.rd && bus.addr == LEP_ADDR_CTRL |=> reg_rdata_out[LEP_BIT_PWR] == ($past(s_r.pwr) == LEP_UP);
    endproperty
    a_state_read: assert property (p_state_read) else $error("state bit wrong");

    property p_met_clear;
        @(posedge mclk_in) disable iff (reset_in)
        bus.rd && bus.addr == LEP_ADDR_CTRL && !(s_r.data_sync[1] && !s_r.data_sync[2])
        |=> !s_r.data_met;
    endproperty
    a_met_clear: assert property (p_met_clear) else $error("flag not cleared on read");

    property p_man_sc;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.man |=> !s_r.man || $past(bus.wr);
    endproperty
    a_man_sc: assert property (p_man_sc) else $error("manual bit stuck");

    // An event in the expiry cycle restarts counting, so it is excluded
    property p_idle_clear;
        @(posedge mclk_in) disable iff (reset_in)
        s_r.idle >= 40'(IDLE_CYC - 1) && !(s_r.data_sync[1] && !s_r.data_sync[2])
        && !(s_r.err_sync[1] && !s_r.err_sync[2]) |=> s_r.data_cnt == 4'h0 && s_r.err_cnt == 4'h0;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("counters not cleared");

    property p_disabled_line;
        @(posedge mclk_in) disable iff (reset_in)
        !s_r.en |-> line_power_out;
    endproperty
    a_disabled_line: assert property (p_disabled_line) else $error("line off while disabled");

    c_up: cover property (@(posedge mclk_in) disable iff (reset_in) s_r.start);
    c_down: cover property (@(posedge mclk_in) disable iff (reset_in)
        s_r.pwr == LEP_UP ##1 s_r.pwr == LEP_DOWN);
    c_irq: cover property (@(posedge mclk_in) disable iff (reset_in) irq_out);
    c_single: cover property (@(posedge mclk_in) disable iff (reset_in) s_r.start && s_r.bdis);
    c_manual: cover property (@(posedge mclk_in) disable iff (reset_in) s_r.en && s_r.man);
endmodule

// >>> logic/lep_pulse_gen.sv
`timescale 1ns/1ps
module lep_pulse_gen
    import lep_pkg::*;
#(
    parameter int BURST = LEP_BURST_LEN,
    parameter int WIDTH = LEP_PULSE_CYC
)(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Control
    input wire logic start_in,
    input wire logic single_in,
    // Pulse and busy outputs
    output logic pulse_out,
    output logic busy_out
);
    typedef struct packed {
        logic [7:0] left;
        logic [7:0] cyc;
        logic pulse;
        logic busy;
    } lep_pg_t;
    lep_pg_t s_r, s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (start_in && !s_r.busy)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.pulse = 1'b1;
            s_nxt.cyc = 8'h00;
            s_nxt.left = single_in ? 8'h01 : 8'(BURST);
        end
        else if (s_r.busy)
        begin
            // Equal high and low phases per pulse
            s_nxt.cyc = s_r.cyc + 8'h01;
            if (s_r.cyc == 8'(WIDTH - 1))
            begin
                s_nxt.cyc = 8'h00;
                s_nxt.pulse = 1'b0;
                if (!s_r.pulse)
                begin
                    s_nxt.left = s_r.left - 8'h01;
                    s_nxt.busy = (s_r.left != 8'h01);
                    s_nxt.pulse = (s_r.left != 8'h01);
                end
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign pulse_out = s_r.pulse;
    assign busy_out = s_r.busy;
endmodule

// >>> tb/lep_line_partner.sv
`timescale 1ns/1ps
module lep_line_partner (
    // Clock
    input wire logic mclk_in,
    // Line sense toward the block
    output logic energy_out,
    output logic data_event_out,
    output logic error_event_out,
    // Pulses from the block
    input wire logic sense_pulse_in
);
    int pulse_cnt = 0;
    logic pulse_d = 1'b0;

    initial
    begin
        energy_out = 1'b0;
        data_event_out = 1'b0;
        error_event_out = 1'b0;
    end

    always @(posedge mclk_in)
    begin
        pulse_d <= sense_pulse_in;
        if (sense_pulse_in && !pulse_d)
            pulse_cnt <= pulse_cnt + 1;
    end

    task automatic set_energy(input logic v);
        @(posedge mclk_in);
        energy_out <= v;
    endtask

    // Events last 4 cycles so the block's synchroniser cannot miss them
    task automatic send_event(input logic err);
        @(posedge mclk_in);
        if (err)
            error_event_out <= 1'b1;
        else
            data_event_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        error_event_out <= 1'b0;
        data_event_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule

// >>> tb/test_line_energy_power_control.sv
`timescale 1ns/1ps
module test_line_energy_power_control;
    import lep_pkg::*;
    logic mclk_in;
    logic reset_in;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] rdata;
    logic energy, data_ev, err_ev, line_power, pulse, irq;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int c0;

    lep_power_ctrl #(.IDLE_CYC(50)) uut (
        .mclk_in(mclk_in), .reset_in(reset_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .energy_in(energy), .data_event_in(data_ev), .error_event_in(err_ev),
        .line_power_out(line_power), .sense_pulse_out(pulse), .irq_out(irq)
    );

    lep_line_partner line (
        .mclk_in(mclk_in), .energy_out(energy), .data_event_out(data_ev),
        .error_event_out(err_ev), .sense_pulse_in(pulse)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("FAIL %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk_in);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk_in);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic wait_pwr(input logic exp);
        int n;
        n = 0;
        #1;
        while (line_power !== exp && n < 40)
        begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk({15'h0000, line_power}, {15'h0000, exp});
    endtask

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge mclk_in);
        #1;
        chk({15'h0000, irq}, {15'h0000, exp});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(LEP_ADDR_CTRL, 16'h6011);
        rd_chk(LEP_ADDR_IRQ_STAT, 16'h0000);
        wr(5'h00, 16'hffff);
        rd_chk(5'h00, 16'h0000);
        // Power state bit not checked while sensing is off
        line.send_event(1'b0);
        // Long enough for the idle clear, so no stale count wakes the next scenario
        repeat (60) @(posedge mclk_in);
        chk({15'h0000, line_power}, 16'h0001);
    endtask

    task automatic t_wake;
        wr(LEP_ADDR_IRQ_MASK, 16'h0003);
        rd_chk(LEP_ADDR_IRQ_MASK, 16'h0003);
        wr(LEP_ADDR_CTRL, 16'he011);
        wait_pwr(1'b0);
        wr(LEP_ADDR_IRQ_STAT, 16'h000f);
        line.set_energy(1'b1);
        c0 = line.pulse_cnt;
        line.send_event(1'b0);
        wait_pwr(1'b1);
        rd_chk(LEP_ADDR_CTRL, 16'he511);
        rd_chk(LEP_ADDR_CTRL, 16'he411);
        chk_irq(1'b1);
        rd_chk(LEP_ADDR_IRQ_STAT, 16'h0005);
        wr(LEP_ADDR_IRQ_STAT, 16'h0001);
        chk_irq(1'b0);
        repeat (80) @(posedge mclk_in);
        chk(16'(line.pulse_cnt - c0), 16'h0004);
        line.send_event(1'b1);
        repeat (4) @(posedge mclk_in);
        rd_chk(LEP_ADDR_CTRL, 16'he611);
        rd_chk(LEP_ADDR_IRQ_STAT, 16'h000c);
    endtask

    task automatic t_sleep;
        line.set_energy(1'b0);
        wait_pwr(1'b0);
        rd_chk(LEP_ADDR_CTRL, 16'he011);
        chk_irq(1'b1);
        wr(LEP_ADDR_IRQ_MASK, 16'h0000);
        chk_irq(1'b0);
        wr(LEP_ADDR_IRQ_STAT, 16'h000f);
        rd_chk(LEP_ADDR_IRQ_STAT, 16'h0000);
    endtask

    task automatic t_manual;
        c0 = line.pulse_cnt;
        // Auto wake and sleep bits are written as zero, so software owns the timing
        wr(LEP_ADDR_CTRL, 16'h9811);
        wait_pwr(1'b1);
        rd_chk(LEP_ADDR_CTRL, 16'h8c11);
        repeat (40) @(posedge mclk_in);
        chk(16'(line.pulse_cnt - c0), 16'h0001);
        chk({15'h0000, line_power}, 16'h0001);
        wr(LEP_ADDR_CTRL, 16'h9811);
        wait_pwr(1'b0);
    endtask

    task automatic t_idle;
        line.set_energy(1'b1);
        wr(LEP_ADDR_CTRL, 16'he012);
        line.send_event(1'b0);
        repeat (80) @(posedge mclk_in);
        line.send_event(1'b0);
        repeat (20) @(posedge mclk_in);
        chk({15'h0000, line_power}, 16'h0000);
        line.send_event(1'b0);
        wait_pwr(1'b1);
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    initial
    begin
        reset_in <= 1'b1;
        addr <= 5'h00;
        wdata <= 16'h0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset();
        t_wake();
        t_sleep();
        t_manual();
        t_idle();
        stop_test();
    end
endmodule
